// ===== flexible_operand_barrel_shifter.sv
`timescale 1ns/1ps
// How it works
// - immediate accepts an eight-bit pattern moved left anywhere in the word
// - immediate accepts byte replicated in bytes 0/2, 1/3, or all four
// - shifted-byte immediate above 255 loads carry with its top bit
// - other immediates leave carry untouched
// - values written to the program counter carry bit zero set to one
// - shift lengths: right shifts 1 to 32, left and rotate 1 to 31
// - no shift or left shift by zero passes the source unchanged
// - shifting feeds the operation only; source register untouched
// - zero-length shift other than rotate through carry never updates carry; nonzero flag-setting shifts other than no shift do
// - arithmetic right shift fills top bits with the sign bit
// - arithmetic right shift carry is source bit n-1
// - arithmetic shift of 32 or more gives sign bit everywhere
// - logical right shift clears the top n bits
// - logical right shift carry is source bit n-1
// - logical shift 32+ gives zero; 33+ clears carry
// - logical left shift clears the bottom n bits
// - left shift carry is source bit 32-n; zero length keeps carry
// - rotate right wraps the low n bits to the top
// - rotate right carry is source bit n-1
// - rotate by 32 returns source with sign carry; beyond 32 subtract 32
// - rotate through carry inserts carry on top, loads carry from bit 0
module flexible_operand_barrel_shifter
    import shifter_pkg::*;
(
    input  wire logic               clk,         // core clock
    input  wire logic               rst,         // async reset, high
    input  wire logic               clk_en,      // freezes state when low
    input  wire operand_ctl_s       ctl,         // decoder control
    input  wire logic [WORD_W-1:0]  shift_source_register, // source value
    input  wire logic               exec_valid,  // instruction executes
    input  wire logic               pc_write,    // pc written by exchange/load
    input  wire logic [WORD_W-1:0]  pc_value,    // value bound for pc
    output logic      [WORD_W-1:0]  flexible_second_operand, // operand to alu
    output logic                    shifter_carry, // shifter carry-out
    output logic                    carry_flag,  // stored carry flag
    output logic      [WORD_W-1:0]  pc_target    // value loaded into pc
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // rotate right by a five-bit amount
    function automatic logic [WORD_W-1:0] rot_word
    (
        input logic [WORD_W-1:0] v,
        input logic [ROT_W-1:0]  n
    );
        logic [2*WORD_W-1:0] d;
        d = {v, v} >> n;
        return d[WORD_W-1:0];
    endfunction : rot_word

    // pick one source bit by index, zero when out of range
    function automatic logic pick_bit
    (
        input logic [WORD_W-1:0] v,
        input logic [AMT_W-1:0]  idx
    );
        logic r;
        r = 1'b0;
        if (idx < LEN_WORD)
            r = v[idx[ROT_W-1:0]];
        return r;
    endfunction : pick_bit

    ////////////////////////////////////////////////////////////////////////
    // immediate expansion

    logic [WORD_W-1:0] imm_value;
    logic              imm_carry_upd;
    logic              imm_carry_val;

    imm_expander u_imm
    (
        .kind      (ctl.imm_kind),
        .pattern   (ctl.imm_byte),
        .left      (ctl.imm_left),
        .value     (imm_value),
        .carry_upd (imm_carry_upd),
        .carry_val (imm_carry_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // register form barrel shifter, purely combinational so the operand
    // settles in the execute cycle; the source is only read, never written

    logic              carry_q;
    logic              carry_d;
    shift_res_s        reg_res;
    shift_res_s        op_res;
    logic [WORD_W-1:0] src;
    logic [AMT_W-1:0]  n;
    logic [AMT_W-1:0]  nm1;
    logic [AMT_W-1:0]  rot_n;
    logic [WORD_W-1:0] sign_fill;

    assign src = shift_source_register;
    assign n   = ctl.shift_len;
    assign nm1 = n - 8'h01;

    // shift kinds
    always_comb
    begin
        reg_res.value       = src;
        reg_res.carry       = carry_q;
        reg_res.carry_valid = 1'b0;
        rot_n               = LEN_ZERO;
        sign_fill           = WORD_ZERO;
        if (n == LEN_ZERO && ctl.shift_kind != SHIFT_ROT_CARRY)
        begin
            reg_res.value       = src;
            reg_res.carry_valid = 1'b0;
        end
        else
        begin
            reg_res.carry_valid = 1'b1;
            unique case (ctl.shift_kind)
                SHIFT_NONE:
                begin
                    reg_res.value       = src;
                    reg_res.carry_valid = 1'b0;
                end
                SHIFT_LEFT:
                begin
                    if (n < LEN_WORD)
                    begin
                        reg_res.value = src << n;
                        reg_res.carry = pick_bit(src, LEN_WORD - n);
                    end
                    else
                    begin
                        reg_res.value = WORD_ZERO;
                        reg_res.carry = (n == LEN_WORD) ? src[0] : 1'b0;
                    end
                end
                SHIFT_RIGHT:
                begin
                    if (n < LEN_WORD)
                        reg_res.value = src >> n;
                    else
                        reg_res.value = WORD_ZERO;
                    reg_res.carry = pick_bit(src, nm1);
                end
                SHIFT_ARITH:
                begin
                    sign_fill = {WORD_W{src[SIGN_BIT]}};
                    if (n < LEN_WORD)
                    begin
                        // only the top n bits take the sign copy
                        reg_res.value = (src >> n)
                            | (sign_fill & ~(sign_fill >> n));
                        reg_res.carry = pick_bit(src, nm1);
                    end
                    else
                    begin
                        reg_res.value = sign_fill;
                        reg_res.carry = src[SIGN_BIT];
                    end
                end
                SHIFT_ROTATE:
                begin
                    // lengths past 32 fold back by whole words
                    rot_n = n & LEN_MASK5;
                    reg_res.value = rot_word(src, rot_n[ROT_W-1:0]);
                    if (rot_n == LEN_ZERO)
                        reg_res.carry = src[SIGN_BIT];
                    else
                        reg_res.carry = src[rot_n[ROT_W-1:0] - 5'd1];
                end
                SHIFT_ROT_CARRY:
                begin
                    reg_res.value = {carry_q, src[WORD_W-1:1]};
                    reg_res.carry = src[0];
                end
                default:
                begin
                    reg_res.value       = src;
                    reg_res.carry_valid = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand selection

    always_comb
    begin
        if (ctl.use_imm)
        begin
            op_res.value       = imm_value;
            op_res.carry       = imm_carry_upd ? imm_carry_val : carry_q;
            op_res.carry_valid = imm_carry_upd;
        end
        else
        begin
            op_res = reg_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carry flag and output registers; the operand path itself is decided
    // within the cycle and only sampled here so outputs come from flops

    logic [WORD_W-1:0] operand_q;
    logic [WORD_W-1:0] operand_d;
    logic              sh_carry_q;
    logic              sh_carry_d;
    logic [WORD_W-1:0] pc_q;
    logic [WORD_W-1:0] pc_d;

    // next values
    always_comb
    begin
        operand_d  = op_res.value;
        sh_carry_d = op_res.carry;
        carry_d    = carry_q;
        pc_d       = pc_q;
        if (exec_valid && ctl.set_flags)
        begin
            if (ctl.arith_op)
                carry_d = ctl.adder_carry;
            else if (op_res.carry_valid)
                carry_d = op_res.carry;
        end
        // only the compact instruction set exists, so bit zero is forced
        if (exec_valid && pc_write)
            pc_d = pc_value | PC_BIT0_SET;
    end

    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            carry_q    <= CARRY_RST;
            operand_q  <= WORD_ZERO;
            sh_carry_q <= CARRY_RST;
            pc_q       <= PC_BIT0_SET;
        end
        else if (clk_en)
        begin
            carry_q    <= carry_d;
            operand_q  <= operand_d;
            sh_carry_q <= sh_carry_d;
            pc_q       <= pc_d;
        end
    end

    assign flexible_second_operand = operand_q;
    assign shifter_carry           = sh_carry_q;
    assign carry_flag              = carry_q;
    assign pc_target               = pc_q;

endmodule : flexible_operand_barrel_shifter

// ===== shifter_pkg.sv
package shifter_pkg;

    localparam int unsigned WORD_W    = 32;
    localparam int unsigned AMT_W     = 8;   // shift length, register form up to 255
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned ROT_W     = 5;   // rotation field of shifted-byte immediate
    localparam int unsigned SIGN_BIT  = 31;
    localparam int unsigned BYTE_MAX  = 255;

    localparam logic [AMT_W-1:0] LEN_ZERO   = 8'h00;
    localparam logic [AMT_W-1:0] LEN_WORD   = 8'h20;  // 32
    localparam logic [AMT_W-1:0] LEN_BEYOND = 8'h21;  // 33
    localparam logic [AMT_W-1:0] LEN_MASK5  = 8'h1f;
    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [WORD_W-1:0] BYTE_LIM  = 32'h0000_00ff;
    localparam logic [WORD_W-1:0] PC_BIT0_SET = 32'h0000_0001;
    localparam logic             CARRY_RST  = 1'b0;

    // shift kind applied to a register second operand
    typedef enum logic [2:0]
    {
        SHIFT_NONE      = 3'b000,
        SHIFT_LEFT      = 3'b001,
        SHIFT_RIGHT     = 3'b011,
        SHIFT_ARITH     = 3'b010,
        SHIFT_ROTATE    = 3'b110,
        SHIFT_ROT_CARRY = 3'b111
    } shift_kind_e;

    // encoded immediate forms
    typedef enum logic [2:0]
    {
        IMM_SHIFTED = 3'b000,
        IMM_REP_02  = 3'b001,
        IMM_REP_13  = 3'b011,
        IMM_REP_ALL = 3'b010
    } imm_kind_e;

    // per-instruction control from the decoder
    typedef struct packed
    {
        logic        use_imm;     // immediate form instead of register
        imm_kind_e   imm_kind;
        logic [BYTE_W-1:0] imm_byte;
        logic [ROT_W-1:0]  imm_left;  // left move of the byte
        shift_kind_e shift_kind;
        logic [AMT_W-1:0]  shift_len;
        logic        set_flags;   // flag-setting instruction
        logic        arith_op;    // add, subtract, compare
        logic        adder_carry; // carry from the alu adder
    } operand_ctl_s;

    typedef struct packed
    {
        logic [WORD_W-1:0] value;
        logic              carry;
        logic              carry_valid; // shifter wants to update carry
    } shift_res_s;

endpackage : shifter_pkg

// ===== imm_expander.sv
`timescale 1ns/1ps
module imm_expander
    import shifter_pkg::*;
(
    input  wire imm_kind_e          kind,      // immediate form
    input  wire logic [BYTE_W-1:0]  pattern,   // eight-bit pattern
    input  wire logic [ROT_W-1:0]   left,      // left move amount
    output logic      [WORD_W-1:0]  value,     // expanded constant
    output logic                    carry_upd, // carry must be written
    output logic                    carry_val  // carry value
);

    logic [2*WORD_W-1:0] wide;

    // expand the encoded constant and its carry effect
    always_comb
    begin
        wide      = {{(WORD_W){1'b0}}, {(WORD_W-BYTE_W){1'b0}}, pattern};
        wide      = wide << left;
        value     = WORD_ZERO;
        carry_upd = 1'b0;
        unique case (kind)
            IMM_SHIFTED:
            begin
                value     = wide[WORD_W-1:0] | wide[2*WORD_W-1:WORD_W];
                carry_upd = (value > BYTE_LIM);
            end
            IMM_REP_02:  value = {8'h00, pattern, 8'h00, pattern};
            IMM_REP_13:  value = {pattern, 8'h00, pattern, 8'h00};
            IMM_REP_ALL: value = {pattern, pattern, pattern, pattern};
            default:     value = WORD_ZERO;
        endcase
        carry_val = value[SIGN_BIT];
    end

endmodule : imm_expander

// ===== shifter_props.sv
`timescale 1ns/1ps
module shifter_props
    import shifter_pkg::*;
(
    input wire logic              clk,     // core clock
    input wire logic              rst,     // async reset
    input wire logic              clk_en,  // state enable
    input wire operand_ctl_s      ctl,     // decoder control
    input wire logic [WORD_W-1:0] shift_source_register, // source
    input wire logic              exec_valid, // executes
    input wire logic              pc_write,   // pc load
    input wire logic [WORD_W-1:0] pc_value,   // pc value
    input wire logic [WORD_W-1:0] flexible_second_operand, // operand
    input wire logic              shifter_carry, // carry out
    input wire logic              carry_flag,    // stored flag
    input wire logic [WORD_W-1:0] pc_target      // pc out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // qualifiers shared by several checks
    wire logic rg = clk_en && !ctl.use_imm;
    wire logic fs = clk_en && exec_valid && ctl.set_flags;
    ////////////////////////////////////////
    AST_PC_BIT0: assert property (pc_target[0])
        else $error("pc bit zero low");
    AST_PC_LOAD: assert property (clk_en && exec_valid && pc_write |=>
        pc_target == ($past(pc_value) | PC_BIT0_SET))
        else $error("pc load value");
    AST_FREEZE: assert property (!clk_en |=> $stable(carry_flag) &&
        $stable(flexible_second_operand) && $stable(pc_target))
        else $error("state moved while frozen");
    AST_NO_SHIFT: assert property (rg && (ctl.shift_kind == SHIFT_NONE ||
        ctl.shift_kind == SHIFT_LEFT && ctl.shift_len == LEN_ZERO) |=>
        flexible_second_operand == $past(shift_source_register))
        else $error("unshifted operand");
    AST_ZERO_KEEP: assert property (fs && rg && !ctl.arith_op &&
        ctl.shift_kind != SHIFT_ROT_CARRY && ctl.shift_len == LEN_ZERO |=>
        $stable(carry_flag))
        else $error("zero length touched carry");
    AST_NO_SET: assert property (clk_en && !(exec_valid && ctl.set_flags)
        |=> $stable(carry_flag))
        else $error("carry changed without set");
    AST_ADDER: assert property (fs && ctl.arith_op |=>
        carry_flag == $past(ctl.adder_carry))
        else $error("adder carry ignored");
    AST_ARITH_WIDE: assert property (rg && ctl.shift_kind == SHIFT_ARITH &&
        ctl.shift_len >= LEN_WORD |=>
        flexible_second_operand == {32{$past(shift_source_register[31])}}
        && shifter_carry == $past(shift_source_register[31]))
        else $error("wide arithmetic shift");
    AST_ROT_CARRY: assert property (rg && ctl.shift_kind == SHIFT_ROT_CARRY
        |=>
        flexible_second_operand == {$past(carry_flag),
        $past(shift_source_register[31:1])} &&
        shifter_carry == $past(shift_source_register[0]))
        else $error("rotate through carry");
    AST_REP_ALL: assert property (clk_en && ctl.use_imm &&
        ctl.imm_kind == IMM_REP_ALL |=>
        flexible_second_operand == {4{$past(ctl.imm_byte)}})
        else $error("replicated byte");
    // main scenarios reached
    COV_ROT_CARRY: cover property (fs && rg &&
        ctl.shift_kind == SHIFT_ROT_CARRY);
    COV_IMM: cover property (fs && ctl.use_imm);
    COV_PC: cover property (clk_en && exec_valid && pc_write);
endmodule : shifter_props

bind flexible_operand_barrel_shifter shifter_props u_props (.clk(clk),
    .rst(rst), .clk_en(clk_en), .ctl(ctl), .exec_valid(exec_valid),
    .shift_source_register(shift_source_register), .pc_write(pc_write),
    .pc_value(pc_value), .flexible_second_operand(flexible_second_operand),
    .shifter_carry(shifter_carry), .carry_flag(carry_flag),
    .pc_target(pc_target));

// ===== decoder_model.sv
`timescale 1ns/1ps
module decoder_model
    import shifter_pkg::*;
(
    input  wire logic [31:0]  rnd,     // random draw
    input  wire logic         wide,    // allow register lengths to 255
    input  wire logic         use_fix, // pass fixed control through
    input  wire operand_ctl_s fix,     // fixed control
    output operand_ctl_s      ctl      // control to the shifter
);
    // only encodable kinds; lengths stay legal unless wide is asked for
    always_comb
    begin
        ctl = fix;
        if (!use_fix)
        begin
            ctl.use_imm  = rnd[0];
            ctl.imm_kind = imm_kind_e'({1'b0, rnd[2:1]});
            ctl.imm_byte = rnd[10:3];
            ctl.imm_left = rnd[15:11];
            case (rnd[18:16])
                3'h0:    ctl.shift_kind = SHIFT_NONE;
                3'h1:    ctl.shift_kind = SHIFT_LEFT;
                3'h2:    ctl.shift_kind = SHIFT_ARITH;
                3'h3:    ctl.shift_kind = SHIFT_RIGHT;
                3'h4:    ctl.shift_kind = SHIFT_ROT_CARRY;
                default: ctl.shift_kind = SHIFT_ROTATE;
            endcase
            ctl.shift_len = wide ? rnd[26:19] : {3'h0, rnd[23:19]} +
                8'(ctl.shift_kind inside {SHIFT_RIGHT, SHIFT_ARITH});
            ctl.set_flags   = rnd[27];
            ctl.arith_op    = rnd[28] & rnd[29];
            ctl.adder_carry = rnd[30];
        end
    end
endmodule : decoder_model

// ===== flexible_operand_barrel_shifter_tb.sv
`timescale 1ns/1ps
module flexible_operand_barrel_shifter_tb;
    import shifter_pkg::*;
    logic         clk = 0, rst = 1, clk_en = 0, exec_valid = 0;
    logic         pc_write = 0, wide = 0, use_fix = 0;
    logic [31:0]  rnd = 0, src = 0, pc_val = 0, seed = 32'h43bf_762e;
    logic [31:0]  op, pc, e_op = 0, e_pc = 32'h0000_0001;
    logic         sc, cf, e_sc = 0, e_cf = 0;
    operand_ctl_s fix = '0, ctl;
    int           fails = 0, tests_run = 0;
    shift_kind_e  kl [6] = '{SHIFT_NONE, SHIFT_LEFT, SHIFT_RIGHT,
                             SHIFT_ARITH, SHIFT_ROTATE, SHIFT_ROT_CARRY};
    int           ln [6] = '{0, 1, 31, 32, 33, 64};

    always #12.5 clk = ~clk;
    decoder_model pm (.rnd(rnd), .wide(wide), .use_fix(use_fix),
                      .fix(fix), .ctl(ctl));
    flexible_operand_barrel_shifter uut (.clk(clk), .rst(rst),
        .clk_en(clk_en), .ctl(ctl), .shift_source_register(src),
        .exec_valid(exec_valid), .pc_write(pc_write), .pc_value(pc_val),
        .flexible_second_operand(op), .shifter_carry(sc),
        .carry_flag(cf), .pc_target(pc));
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // expected {update, carry, value}; 33-bit shifts keep the carry bit
    function automatic logic [33:0] ref_op(operand_ctl_s c,
                                           logic [31:0] s, logic f);
        logic [63:0] w;
        logic [31:0] v;
        logic        cy;
        int          n;
        n  = int'(c.shift_len);
        v  = s;
        cy = f;
        w  = {56'h0, c.imm_byte} << c.imm_left;
        if (c.use_imm)
        begin
            case (c.imm_kind)
                IMM_SHIFTED: v = w[31:0] | w[63:32];
                IMM_REP_02:  v = {2{8'h00, c.imm_byte}};
                IMM_REP_13:  v = {2{c.imm_byte, 8'h00}};
                IMM_REP_ALL: v = {4{c.imm_byte}};
                default:     v = '0;
            endcase
            return {c.imm_kind == IMM_SHIFTED && v > BYTE_LIM, v[31], v};
        end
        if (n == 0 && c.shift_kind != SHIFT_ROT_CARRY)
            return {1'b0, f, s};
        case (c.shift_kind)
            SHIFT_LEFT:      {cy, v} = {1'b0, s} << n;
            SHIFT_RIGHT:     {v, cy} = {s, 1'b0} >> n;
            SHIFT_ARITH:     {v, cy} = $signed({s, 1'b0}) >>> n;
            SHIFT_ROTATE:    v = 32'({s, s} >> (n % 32));
            SHIFT_ROT_CARRY: {v, cy} = {f, s};
            default:         v = s;
        endcase
        if (c.shift_kind == SHIFT_ROTATE)
            cy = v[31];
        return {c.shift_kind != SHIFT_NONE, cy, v};
    endfunction : ref_op

    // one edge: predict from the applied inputs, then compare after it
    task automatic step;
        logic [33:0] r;
        #1;
        r = ref_op(ctl, src, e_cf);
        if (rst)
            {e_op, e_sc, e_cf, e_pc} = {32'h0, 1'b0, 1'b0, PC_BIT0_SET};
        else if (clk_en)
        begin
            e_op = r[31:0];
            e_sc = r[33] ? r[32] : e_cf;
            if (exec_valid && ctl.set_flags)
                e_cf = ctl.arith_op ? ctl.adder_carry : e_sc;
            if (exec_valid && pc_write)
                e_pc = pc_val | PC_BIT0_SET;
        end
        @(negedge clk);
        tests_run++;
        if ({op, sc, cf, pc} !== {e_op, e_sc, e_cf, e_pc})
        begin
            fails++;
            $display("wrong value at %0t: op %h/%h c %b%b/%b%b", $time,
                     op, e_op, sc, cf, e_sc, e_cf);
        end
    endtask : step

    task automatic finish_test;
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////
    // watchdog: the sequence needs about 2060 cycles
    initial
    begin
        #(25 * 6000);
        fails++;
        finish_test();
    end

    initial
    begin
        repeat (3) step();
        rst = 0;
        {use_fix, clk_en, exec_valid, fix.set_flags} = 4'hf;
        // every kind against boundary lengths, flags set
        foreach (kl[k])
            foreach (ln[j])
            begin
                seed = xs(seed);
                {src, fix.shift_kind, fix.shift_len} = {seed, kl[k], 8'(ln[j])};
                step();
            end
        // every immediate form at moves 0 to 28 in steps of 7
        fix.use_imm = 1;
        for (int k = 0; k < 4; k++)
            for (int j = 0; j < 32; j += 7)
            begin
                seed = xs(seed);
                fix.imm_kind = imm_kind_e'(k == 2 ? 3 : k == 3 ? 2 : k);
                {fix.imm_byte, fix.imm_left} = {seed[7:0] | 8'h81, 5'(j)};
                step();
            end
        // random traffic, stalls, pc loads and one mid-run reset
        use_fix = 0;
        for (int i = 0; i < 2000; i++)
        begin
            seed = xs(seed);
            rnd = seed;
            seed = xs(seed);
            src = seed;
            seed = xs(seed);
            {clk_en, exec_valid, pc_write, wide} = {|seed[1:0], seed[4:2]};
            pc_val = xs(seed);
            rst = (i == 1000);
            step();
        end
        finish_test();
    end
endmodule : flexible_operand_barrel_shifter_tb
